// ### pld_pkg.sv
// Constants, types and register map of the macrocell array block
package pld_pkg;
  localparam int N_IN = 12;
  localparam int N_MC = 10;
  localparam int N_LIT = N_IN + N_MC;
  localparam int SIG_WORDS = 2;

  // Power-on clear interval, a longest time, so the count rounds down
  localparam int CLK_PERIOD_NS = 40;
  localparam int POC_INTERVAL_NS = 1000;
  localparam int POC_CYCLES = POC_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int POC_CNT_W = $clog2(POC_CYCLES + 1);
  localparam logic [POC_CNT_W-1:0] POC_RST = POC_CNT_W'(POC_CYCLES);

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_REGMODE = 8'h04;
  localparam logic [7:0] OFS_POL = 8'h08;
  localparam logic [7:0] OFS_SEC = 8'h0C;
  localparam logic [7:0] OFS_PRELOAD = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_SIG0 = 8'h20;
  localparam logic [7:0] OFS_SIG1 = 8'h24;
  localparam logic [1:0] OFS_TT_HI = 2'h1;
  localparam logic [1:0] OFS_TC_HI = 2'h2;

  localparam int CTRL_OE_BIT = 0;
  localparam int SEC_FUSE_BIT = 0;
  localparam int SEC_ERASE_BIT = 1;
  localparam int STAT_IO_LSB = 12;
  localparam int STAT_BUSY_BIT = 24;

  localparam logic CTRL_OE_RST = 1'b0;
  localparam logic FUSE_RST = 1'b0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
  } ahb_addr_t;

  typedef struct packed {
    logic [N_IN-1:0] value;
    logic [N_IN-1:0] driven;
  } in_pins_t;

  typedef struct packed {
    logic [N_MC-1:0] value;
    logic [N_MC-1:0] driven;
  } io_pins_t;

  typedef enum {
    R_CTRL, R_REGMODE, R_POL, R_SEC, R_PRE, R_STAT, R_SIG, R_TT, R_TC, R_NONE
  } reg_sel_t;

  function automatic reg_sel_t decode(input logic [7:0] a);
    reg_sel_t r;
    r = R_NONE;
    if (a[7:6] == OFS_TT_HI && int'(a[5:2]) < N_MC && a[1:0] == 2'h0) begin
      r = R_TT;
    end else if (a[7:6] == OFS_TC_HI && int'(a[5:2]) < N_MC &&
                 a[1:0] == 2'h0) begin
      r = R_TC;
    end else begin
      case (a)
        OFS_CTRL: r = R_CTRL;
        OFS_REGMODE: r = R_REGMODE;
        OFS_POL: r = R_POL;
        OFS_SEC: r = R_SEC;
        OFS_PRELOAD: r = R_PRE;
        OFS_STATUS: r = R_STAT;
        OFS_SIG0, OFS_SIG1: r = R_SIG;
        default: r = R_NONE;
      endcase
    end
    return r;
  endfunction : decode
endpackage : pld_pkg

// ### sig_store.sv
// Word-wide user signature memory with registered, write-first read data
module sig_store #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic re,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      rdata <= '0;
    end else begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      // Bypass so a read in the same cycle as a write to its word sees the new word
      if (re) begin
        rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
      end
    end
  end
endmodule : sig_store

// ### pld_macrocells.sv
// Macrocell array with power-on clear, preload, security and signature
// Operation
// RQ1: Registers cleared low after power-on, no clock
// RQ2: Output level follows programmed polarity after clear
// RQ3: Clock pin held stable during clear interval
// RQ4: Setup met before first clock after clear
// RQ5: Each register preloadable high or low
// RQ6: Eight-byte signature readable, secured or not
// RQ7: Fuse blocks pattern verify and preload
// RQ8: Fuse acts immediately; program it last
// RQ9: Keepers hold last driven pin level
// RQ10: Twelve inputs, ten macrocells with feedback
// RQ11: Four modes: polarity by registered/combinational
// RQ12: Registered cells update on clock rising edge
//
// The AHB-Lite slave port and the address map were decided locally.
module pld_macrocells (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input pld_pkg::ahb_addr_t ahb_a,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Device pins
  input wire logic pld_clk,
  input pld_pkg::in_pins_t in_pins,
  input pld_pkg::io_pins_t io_in,
  output logic [pld_pkg::N_MC-1:0] io_out,
  output logic [pld_pkg::N_MC-1:0] io_oe
);
  import pld_pkg::*;

  // Bus state
  logic wr_pend, rd_wait;
  logic next_wr_pend, next_rd_wait, next_hreadyout;
  logic [7:0] ph_addr, next_ph_addr;
  reg_sel_t ph_sel, next_ph_sel;
  logic [31:0] next_hrdata, rd_mux, sig_rdata;
  logic accept;
  // Configuration state
  logic ctrl_oe, fuse, next_ctrl_oe, next_fuse;
  logic [N_MC-1:0] reg_mode, pol_low, next_reg_mode, next_pol_low;
  logic [N_LIT-1:0] tt [N_MC];
  logic [N_LIT-1:0] tc [N_MC];
  logic [N_LIT-1:0] next_tt [N_MC];
  logic [N_LIT-1:0] next_tc [N_MC];
  // Macrocell and pin state
  logic [N_IN-1:0] in_v1, in_v2, in_d1, in_d2, keep_in, next_keep_in;
  logic [N_MC-1:0] io_v1, io_v2, io_d1, io_d2, keep_io, next_keep_io;
  logic clk_s1, clk_s2, clk_s3;
  logic [POC_CNT_W-1:0] poc_cnt, next_poc_cnt;
  logic [N_MC-1:0] q, next_q, term, next_io_out, next_io_oe;
  logic [N_LIT-1:0] lits;
  logic busy, clk_rise, wr_en, preload_wr, erase;

  // Bus: reads take one wait state, writes none
  assign accept = ahb_a.hsel && hready && ahb_a.htrans[1];
  assign wr_en = wr_pend;
  assign preload_wr = wr_en && ph_sel == R_PRE && !fuse && !busy; // RQ5 RQ7
  assign erase = wr_en && ph_sel == R_SEC && hwdata[SEC_ERASE_BIT];

  always_comb begin
    rd_mux = WORD_ZERO;
    unique case (ph_sel)
      R_CTRL: rd_mux[CTRL_OE_BIT] = ctrl_oe;
      R_REGMODE: rd_mux[N_MC-1:0] = fuse ? '0 : reg_mode; // RQ7
      R_POL: rd_mux[N_MC-1:0] = fuse ? '0 : pol_low; // RQ7
      R_SEC: rd_mux[SEC_FUSE_BIT] = fuse;
      R_PRE: rd_mux[N_MC-1:0] = fuse ? '0 : q; // RQ7
      R_STAT: begin
        rd_mux[N_IN-1:0] = keep_in;
        rd_mux[STAT_IO_LSB +: N_MC] = keep_io;
        rd_mux[STAT_BUSY_BIT] = busy;
      end
      R_SIG: rd_mux = sig_rdata; // RQ6
      R_TT: rd_mux[N_LIT-1:0] = fuse ? '0 : tt[ph_addr[5:2]]; // RQ7
      R_TC: rd_mux[N_LIT-1:0] = fuse ? '0 : tc[ph_addr[5:2]]; // RQ7
      R_NONE: rd_mux = WORD_ZERO;
    endcase
  end

  always_comb begin
    next_wr_pend = accept && ahb_a.hwrite;
    next_rd_wait = accept && !ahb_a.hwrite;
    next_hreadyout = !(accept && !ahb_a.hwrite);
    next_ph_addr = accept ? ahb_a.haddr[7:0] : ph_addr;
    next_ph_sel = accept ? decode(ahb_a.haddr[7:0]) : ph_sel;
    next_hrdata = rd_wait ? rd_mux : hrdata;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_wait <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ph_addr <= 8'h00;
      ph_sel <= R_NONE;
      hrdata <= WORD_ZERO;
    end else begin
      wr_pend <= next_wr_pend;
      rd_wait <= next_rd_wait;
      hreadyout <= next_hreadyout;
      hresp <= 1'b0; // Errors never signalled, every transfer OKAY
      ph_addr <= next_ph_addr;
      ph_sel <= next_ph_sel;
      hrdata <= next_hrdata;
    end
  end

  sig_store #(.WIDTH(32), .DEPTH(SIG_WORDS)) u_sig (
    .clk(hclk),
    .rst_n(hresetn),
    .we(wr_en && ph_sel == R_SIG), // RQ6
    .waddr(ph_addr[2]),
    .wdata(hwdata),
    .re(accept && !ahb_a.hwrite && decode(ahb_a.haddr[7:0]) == R_SIG),
    .raddr(ahb_a.haddr[2]),
    .rdata(sig_rdata)
  );

  // Configuration; erase wipes the pattern and the fuse, not the signature
  always_comb begin
    next_ctrl_oe = ctrl_oe;
    next_reg_mode = reg_mode;
    next_pol_low = pol_low;
    next_fuse = fuse;
    next_tt = tt;
    next_tc = tc;
    if (erase) begin
      next_reg_mode = '0;
      next_pol_low = '0;
      next_fuse = FUSE_RST;
      for (int i = 0; i < N_MC; i++) begin
        next_tt[i] = '0;
        next_tc[i] = '0;
      end
    end else if (wr_en) begin
      unique case (ph_sel)
        R_CTRL: next_ctrl_oe = hwdata[CTRL_OE_BIT];
        R_REGMODE: next_reg_mode = hwdata[N_MC-1:0]; // RQ11
        R_POL: next_pol_low = hwdata[N_MC-1:0]; // RQ11
        R_SEC: next_fuse = fuse | hwdata[SEC_FUSE_BIT]; // RQ8
        R_TT: next_tt[ph_addr[5:2]] = hwdata[N_LIT-1:0];
        R_TC: next_tc[ph_addr[5:2]] = hwdata[N_LIT-1:0];
        R_PRE, R_STAT, R_SIG, R_NONE: next_fuse = fuse;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_oe <= CTRL_OE_RST;
      reg_mode <= '0;
      pol_low <= '0;
      fuse <= FUSE_RST;
      for (int i = 0; i < N_MC; i++) begin
        tt[i] <= '0;
        tc[i] <= '0;
      end
    end else begin
      ctrl_oe <= next_ctrl_oe;
      reg_mode <= next_reg_mode;
      pol_low <= next_pol_low;
      fuse <= next_fuse;
      tt <= next_tt;
      tc <= next_tc;
    end
  end

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {in_v1, in_v2, in_d1, in_d2} <= '0;
      {io_v1, io_v2, io_d1, io_d2} <= '0;
      {clk_s1, clk_s2, clk_s3} <= 3'h0;
    end else begin
      in_v1 <= in_pins.value;
      in_v2 <= in_v1;
      in_d1 <= in_pins.driven;
      in_d2 <= in_d1;
      io_v1 <= io_in.value;
      io_v2 <= io_v1;
      io_d1 <= io_in.driven;
      io_d2 <= io_d1;
      clk_s1 <= pld_clk;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
    end
  end

  // Clock edges during the clear interval are ignored
  assign busy = poc_cnt != '0; // RQ1 RQ3
  assign clk_rise = clk_s2 && !clk_s3 && !busy; // RQ4 RQ12
  // Feedback: register for registered cells, pin keeper otherwise
  assign lits = {(reg_mode & q) | (~reg_mode & keep_io), keep_in}; // RQ10

  // One product term per cell over true and complement literals
  genvar g;
  generate
    for (g = 0; g < N_MC; g++) begin : g_term
      assign term[g] = &(~tt[g] | lits) & &(~tc[g] | ~lits); // RQ10
    end
  endgenerate

  always_comb begin
    next_poc_cnt = busy ? poc_cnt - 1'b1 : poc_cnt;
    next_q = q;
    if (busy) begin
      next_q = '0; // RQ1
    end else if (preload_wr) begin
      next_q = hwdata[N_MC-1:0]; // RQ5
    end else if (clk_rise) begin
      next_q = (reg_mode & term) | (~reg_mode & q); // RQ12
    end
    // Polarity applies after the register, so cleared cells show it
    next_io_out = ((reg_mode & q) | (~reg_mode & term)) ^ pol_low; // RQ2 RQ11
    next_io_oe = {N_MC{ctrl_oe}};
    // Keepers: own drive, else last externally driven level
    next_keep_in = (in_d2 & in_v2) | (~in_d2 & keep_in); // RQ9
    next_keep_io = (io_oe & io_out) | (~io_oe & io_d2 & io_v2) |
                   (~io_oe & ~io_d2 & keep_io); // RQ9
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      poc_cnt <= POC_RST;
      q <= '0; // RQ1
      io_out <= '0;
      io_oe <= '0;
      keep_in <= '0;
      keep_io <= '0;
    end else begin
      poc_cnt <= next_poc_cnt;
      q <= next_q;
      io_out <= next_io_out;
      io_oe <= next_io_oe;
      keep_in <= next_keep_in;
      keep_io <= next_keep_io;
    end
  end

  // Checks
  logic [5:0] age;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      age <= 6'h00;
    end else if (age != 6'h3F) begin
      age <= age + 6'h01;
    end
  end

  a_clear_length: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
    busy == (int'(age) < POC_CYCLES)) else $error("clear interval wrong");
  a_clear_low: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
    busy |=> q == '0) else $error("register not cleared");
  a_out_polarity: assert property (@(posedge hclk) disable iff (!hresetn) // RQ2
    q == '0 |=> ((io_out ^ $past(pol_low)) & $past(reg_mode)) == '0)
    else $error("cleared output ignores polarity");
  a_preload_force: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
    preload_wr |=> q == $past(hwdata[N_MC-1:0])) else $error("preload lost");
  a_preload_lock: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
    wr_en && ph_sel == R_PRE && fuse && !clk_rise && !busy
    |=> $stable(q)) else $error("preload while secured");
  a_verify_lock: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
    rd_wait && fuse && ph_sel inside {R_TT, R_TC, R_PRE, R_POL, R_REGMODE}
    |=> hrdata == WORD_ZERO) else $error("pattern readable while secured");
  a_sig_open: assert property (@(posedge hclk) disable iff (!hresetn) // RQ6
    rd_wait && ph_sel == R_SIG |=> hrdata == $past(sig_rdata) && hreadyout)
    else $error("signature read failed");
  a_fuse_now: assert property (@(posedge hclk) disable iff (!hresetn) // RQ8
    wr_en && ph_sel == R_SEC && hwdata[SEC_FUSE_BIT] &&
    !hwdata[SEC_ERASE_BIT] |=> fuse) else $error("fuse not immediate");
  a_keeper_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
    ((keep_io ^ $past(keep_io)) & ~$past(io_d2) & ~$past(io_oe)) == '0)
    else $error("keeper lost level");
  a_edge_only: assert property (@(posedge hclk) disable iff (!hresetn) // RQ12
    !clk_rise && !preload_wr && !busy |=> $stable(q))
    else $error("register moved without clock");
endmodule : pld_macrocells

// ### pld_board.sv
// Board-side model driving the device clock, input and I/O pins
module pld_board (
  // Clock
  input wire logic hclk,
  // Device outputs
  input wire logic [pld_pkg::N_MC-1:0] io_out,
  input wire logic [pld_pkg::N_MC-1:0] io_oe,
  // Pins driven into the device
  output logic pld_clk,
  output pld_pkg::in_pins_t in_pins,
  output pld_pkg::io_pins_t io_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import pld_pkg::*;
  logic [N_MC-1:0] float_pat = '0;

  // Released I/O lines toggle so a stale level never passes for a hold
  always @(posedge hclk) float_pat <= ~float_pat;

  always_comb begin
    io_in.value = (io_oe & io_out) | (~io_oe & float_pat);
    io_in.driven = '0;
  end

  initial begin
    pld_clk = 1'b0;
    in_pins = '0;
  end

  // A released input shows the inverse of its last level
  task automatic set_in(input logic [N_IN-1:0] v,
                        input logic [N_IN-1:0] drv);
    @(posedge hclk);
    in_pins.value <= (v & drv) | (~in_pins.value & ~drv);
    in_pins.driven <= drv;
  endtask : set_in

  // Inputs settle past the synchroniser before the clock rises
  task automatic pulse();
    repeat (6) @(posedge hclk);
    pld_clk <= 1'b1;
    repeat (4) @(posedge hclk);
    pld_clk <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask : pulse
endmodule : pld_board

// ### test_pld_macrocells.sv
// Self-checking bench for the macrocell array block
module test_pld_macrocells;
  timeunit 1ns;
  timeprecision 1ns;
  import pld_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  ahb_addr_t ahb_a = '0;
  logic [31:0] hwdata = '0;
  logic hreadyout;
  logic hresp;
  logic pld_clk;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] r;
  logic [N_MC-1:0] io_out;
  logic [N_MC-1:0] io_oe;
  logic [N_MC-1:0] pol;
  logic [N_MC-1:0] q = '0;
  in_pins_t in_pins;
  io_pins_t io_in;
  int bad_count = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h0001_3AF4;
  logic [31:0] mdl [int];
  logic fuse = 1'b0;

  always #20 hclk = ~hclk;

  pld_macrocells u_pld_macrocells (.hclk(hclk), .hresetn(hresetn),
    .ahb_a(ahb_a), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pld_clk(pld_clk), .in_pins(in_pins), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe));
  pld_board u_pld_board (.hclk(hclk), .io_out(io_out), .io_oe(io_oe),
    .pld_clk(pld_clk), .in_pins(in_pins), .io_in(io_in));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Secured pattern and register contents read back as zero
  function automatic logic [31:0] expect_rd(input int a);
    if (fuse && (a inside {4, 8, 16} || a >= 64)) return '0;
    if (a == 16) return 32'(q);
    if (a == 12) return 32'(fuse);
    return mdl.exists(a) ? mdl[a] : '0;
  endfunction : expect_rd

  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge hclk);
    ahb_a <= '{1'b1, {24'h0, a}, 2'b10, w, 3'b010};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    ahb_a.htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
    if (a == OFS_SEC && d[1]) begin
      fuse = 1'b0;
      mdl.delete(4);
      mdl.delete(8);
      mdl.delete(64);
      mdl.delete(68);
      mdl.delete(136);
    end else if (a == OFS_SEC) begin
      fuse = fuse | d[0];
    end else if (a == OFS_PRELOAD) begin
      if (!fuse) q = d[9:0];
    end else if (a != 8'h30) begin
      mdl[a] = d;
    end
  endtask : wr

  task automatic rc(input logic [7:0] a, input string nm);
    bus(a, 1'b0, '0);
    chk(nm, rd, expect_rd(a));
  endtask : rc

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    bus(OFS_STATUS, 1'b0, '0);
    chk("busy", 32'(rd[24]), 32'h1);
    for (int a = 0; a < 20; a += 4) rc(8'(a), "reset");
    repeat (POC_CYCLES) @(posedge hclk);
    bus(OFS_STATUS, 1'b0, '0);
    chk("busy", 32'(rd[24]), 32'h0);
    $display("done power-on clear");
    r = rnd();
    pol = r[9:0];
    wr(OFS_CTRL, 32'h1);
    wr(OFS_REGMODE, 32'h3FF);
    wr(OFS_POL, 32'(pol));
    repeat (3) @(posedge hclk);
    chk("io_out", 32'(io_out), 32'(pol));
    chk("io_oe", 32'(io_oe), 32'h3FF);
    r = rnd();
    wr(OFS_PRELOAD, 32'(r[9:0]));
    rc(OFS_PRELOAD, "preload");
    repeat (3) @(posedge hclk);
    chk("io_out", 32'(io_out), 32'(q ^ pol));
    $display("done preload and polarity");
    wr(OFS_SIG0, rnd());
    wr(OFS_SIG1, rnd());
    wr(8'h30, 32'hFFFF_FFFF);
    for (int a = 32; a < 52; a += 4) rc(8'(a), "store");
    $display("done signature");
    // Cell 0 registered on input 0, cell 1 combinational on input 1
    // Cell 2 registered on input 0 low, through the complement mask
    wr(OFS_POL, 32'h0);
    wr(OFS_REGMODE, 32'h3FD);
    wr(8'h40, 32'h1);
    wr(8'h44, 32'h2);
    wr(8'h88, 32'h1);
    rc(8'h44, "term");
    u_pld_board.set_in(12'h003, 12'hFFF);
    repeat (8) @(posedge hclk);
    chk("comb", 32'(io_out[1]), 32'h1);
    u_pld_board.pulse();
    q = {7'h7F, 1'b0, q[1], 1'b1};
    rc(OFS_PRELOAD, "clocked");
    chk("io_out", 32'(io_out), 32'(q | 10'h002));
    u_pld_board.set_in(12'h000, 12'h000);
    repeat (8) @(posedge hclk);
    bus(OFS_STATUS, 1'b0, '0);
    chk("keeper", 32'(rd[11:0]), 32'h3);
    // Release the I/O lines; the board then toggles them
    wr(OFS_CTRL, 32'h0);
    repeat (3) @(posedge hclk);
    chk("io_oe", 32'(io_oe), 32'h0);
    bus(OFS_STATUS, 1'b0, '0);
    chk("io_keeper", 32'(rd[21:12]), 32'(q | 10'h002));
    $display("done array and keepers");
    wr(OFS_SEC, 32'h1);
    rc(OFS_SEC, "fuse");
    for (int a = 4; a < 20; a += 4) rc(8'(a), "secured");
    rc(8'h40, "secured");
    wr(OFS_PRELOAD, 32'h0);
    rc(OFS_SIG0, "store");
    chk("hresp", 32'(hresp), 32'h0);
    wr(OFS_SEC, 32'h3);
    for (int a = 4; a < 20; a += 4) rc(8'(a), "erased");
    $display("done security");
    // Second power-up with the registers of cells 0 and 3 to 9 holding ones
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    q = '0;
    mdl.delete();
    rc(OFS_PRELOAD, "second clear");
    $display("done second clear");
    print_verdict();
  end

  initial begin
    repeat (4000) @(posedge hclk);
    bad_count++;
    print_verdict();
  end
endmodule : test_pld_macrocells
